// ### verilog/cmc_map.vh
// register map, field positions, reset values and timing for the charger mode control
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
`define CMC_ADR_CFG_MODE 8'h00
`define CMC_ADR_CFG_LIMITS 8'h04
`define CMC_ADR_CFG_INPUT 8'h08
`define CMC_ADR_CFG_SELECT 8'h0C
`define CMC_ADR_CFG_PERMIT 8'h10
`define CMC_ADR_STATUS 8'h14
`define CMC_MODE_LSB 0
`define CMC_MODE_MSB 3
`define CMC_FCHG_LSB 4
`define CMC_FCHG_MSB 6
`define CMC_OTG_ILIM_LSB 0
`define CMC_OTG_ILIM_MSB 3
`define CMC_DOC_LSB 4
`define CMC_DOC_MSB 7
`define CMC_ILIM_LSB 0
`define CMC_ILIM_MSB 5
`define CMC_VBYP_LSB 8
`define CMC_VBYP_MSB 11
`define CMC_MANUAL_BIT 0
`define CMC_VINREG_LSB 4
`define CMC_VINREG_MSB 7
`define CMC_PERMIT_BIT 0
`define CMC_ST_VALID_BIT 0
`define CMC_ST_FAULT_BIT 1
`define CMC_ST_CHG_BIT 2
`define CMC_ST_INSW_BIT 3
`define CMC_ST_DETAIL_LSB 4
`define CMC_ST_DETAIL_MSB 7
`define CMC_ST_MODE_LSB 8
`define CMC_ST_MODE_MSB 10
`define CMC_RST_MODE 4'h5
`define CMC_RST_FCHG 3'h3
`define CMC_RST_OTG_ILIM 4'h0
`define CMC_RST_DOC 4'h0
`define CMC_RST_ILIM 6'h00
`define CMC_RST_VBYP 4'h0
`define CMC_RST_VINREG 4'h0
`define CMC_RST_PERMIT 1'h1
`define CMC_DETAIL_TIMER_FAULT 4'h6
`define CMC_CLK_KHZ 20000
`define CMC_MS_TIME 1
`define CMC_MIN_IN_MS 60000
`define CMC_OTG_OFF_MS 300
`define CMC_OTG_ON_MS 60
`define CMC_PQ_MIN 30
`define CMC_FCHG_STEP_MIN 60
`endif

// ### verilog/cmc_top.v
// charger mode decode, otg retry, input limit select and charge safety timers
`timescale 1ns/100ps
`include "cmc_map.vh"

// three-stage pin synchroniser, change taken once stages two and three agree
module cmc_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_o <= s3_ff;
      end
    end
  end
endmodule // cmc_sync3

// minute-resolution safety timer, limit zero disables expiry
module cmc_safety_timer #(
  parameter MIN_MS = 60000
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ms_tick_i,
  input wire clear_i,
  input wire run_i,
  input wire [8:0] limit_i,
  output reg expired_o
);
  reg [16:0] ms_cnt_ff;
  reg [8:0] min_cnt_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_ff <= 17'h00000;
      min_cnt_ff <= 9'h000;
      expired_o <= 1'b0;
    end else if (clear_i) begin
      ms_cnt_ff <= 17'h00000;
      min_cnt_ff <= 9'h000;
      expired_o <= 1'b0;
    end else begin
      if (run_i && ms_tick_i && !expired_o) begin
        if (ms_cnt_ff == MIN_MS[16:0] - 17'h00001) begin
          ms_cnt_ff <= 17'h00000;
          min_cnt_ff <= min_cnt_ff + 9'h001;
        end else begin
          ms_cnt_ff <= ms_cnt_ff + 17'h00001;
        end
      end
      if (limit_i != 9'h000 && min_cnt_ff >= limit_i) begin
        expired_o <= 1'b1;
      end
    end
  end
endmodule // cmc_safety_timer

// Notes on behaviour
// R1: codes 0xA/0xB run otg boost, input switch on, fixed 5.1V output.
// R2: codes 0x8/0x9 run reverse boost, input switch off, bypass node only.
// R3: reverse boost follows programmed bypass setting, no bypass current limit.
// R4: reverse boost discharge overcurrent opens the battery switch.
// R5: otg overload opens input switch, closes again after 300 ms.
// R6: persisting otg overload cycles switch 60 ms closed, 300 ms open.
// R7: otg mode entered only while charge permit pin is high.
// R8: host waits input invalid, raises permit pin, then writes otg code.
// R9: code 0x5 selects charger on, buck on, otg and boost off.
// R10: codes 0x0/0x1 select battery only, everything off.
// R11: codes 0x2,0x3,0x6,0x7,0xC-0xF keep the current mode.
// R12: host never writes 0x4; it clears the permit bit instead.
// R13: charge profile logic itself also turns charging on and off.
// R14: after reset input limit comes from usb detection.
// R15: manual select bit set uses host input limit field instead.
// R16: adaptive loop regulation level field, reset default 4.5V.
// R17: adaptive loop active at 60 mA floor turns charger off.
// R18: precharge plus trickle time limited to 30 minutes.
// R19: fast charge cc, cv, top-off time limited by programmed field.
// R20: timer expiry suspends charging, detail 0x6, status pin released.
// R21: fault exits on input reapply, permit pin or permit bit re-raise.
// R22: each safety timer restarts when its state group is newly entered.
module cmc_top #(
  parameter MS_CYCLES = `CMC_CLK_KHZ * `CMC_MS_TIME,
  parameter MIN_MS = `CMC_MIN_IN_MS
) (
  input wire CLOCK_I,
  input wire RST_N_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire CHARGE_PERMIT_PIN_I,
  input wire INPUT_VALID_I,
  input wire OTG_OVERLOAD_I,
  input wire DISCHARGE_OVERCURRENT_I,
  input wire ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I,
  input wire ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I,
  input wire [5:0] USB_DET_LIMIT_I,
  input wire [2:0] PROFILE_STATE_I,
  input wire PROFILE_CHARGE_REQ_I,
  output reg BUCK_EN_O,
  output reg BOOST_EN_O,
  output reg OTG_EN_O,
  output reg CHARGE_EN_O,
  output reg INPUT_SWITCH_ON_O,
  output reg BATTERY_SWITCH_ON_O,
  output reg BYP_FIXED_5V1_O,
  output reg [3:0] BYP_TARGET_O,
  output reg [3:0] OTG_ILIM_O,
  output reg [3:0] DISCHARGE_OC_THRESH_O,
  output reg [5:0] INPUT_LIMIT_O,
  output reg [3:0] VIN_REG_O,
  output reg STAT_O,
  output reg STAT_OE_O
);
  localparam [2:0] MD_BATT_ONLY = 3'h0;
  localparam [2:0] MD_CHG_OFF = 3'h1;
  localparam [2:0] MD_CHG_ON = 3'h2;
  localparam [2:0] MD_REV_BOOST = 3'h3;
  localparam [2:0] MD_OTG = 3'h4;
  localparam [1:0] OTG_ST_CLOSED = 2'h0;
  localparam [1:0] OTG_ST_OPEN = 2'h1;
  localparam [1:0] OTG_ST_RETRY = 2'h2;
  localparam [2:0] PF_PRECHARGE = 3'h1;
  localparam [2:0] PF_TRICKLE = 3'h2;
  localparam [2:0] PF_FAST_CC = 3'h3;
  localparam [2:0] PF_FAST_CV = 3'h4;
  localparam [2:0] PF_TOPOFF = 3'h5;
  localparam [8:0] OTG_OFF_TICKS = `CMC_OTG_OFF_MS;
  localparam [8:0] OTG_ON_TICKS = `CMC_OTG_ON_MS;
  localparam [8:0] PQ_LIMIT = `CMC_PQ_MIN;
  localparam [8:0] FCHG_STEP = `CMC_FCHG_STEP_MIN;

  reg [3:0] mode_field_ff;
  reg [2:0] fchg_field_ff;
  reg [3:0] otg_ilim_ff;
  reg [3:0] doc_ff;
  reg [5:0] ilim_field_ff;
  reg [3:0] vbyp_ff;
  reg manual_sel_ff;
  reg [3:0] vinreg_ff;
  reg permit_bit_ff;
  reg permit_bit_old_ff;
  reg [2:0] act_mode_ff;
  reg [2:0] nxt_act_mode;
  reg [1:0] otg_st_ff;
  reg [1:0] nxt_otg_st;
  reg [8:0] otg_cnt_ff;
  reg [8:0] nxt_otg_cnt;
  reg [15:0] div_cnt_ff;
  reg ms_tick_ff;
  reg doc_trip_ff;
  reg fault_ff;
  reg pin_old_ff;
  reg valid_old_ff;
  reg [1:0] group_old_ff;
  reg [31:0] rd_data;
  wire pin_s;
  wire valid_s;
  wire ovl_s;
  wire doc_s;
  wire adaptive_input_limit_loop_s;
  wire floor_s;
  wire bus_req;
  wire wr_en;
  wire [3:0] wr_mode;
  wire in_pq;
  wire in_fast;
  wire [1:0] group;
  wire pq_exp;
  wire fast_exp;
  wire pq_clear;
  wire fast_clear;
  wire fault_set;
  wire fault_exit;
  wire charge_run;
  wire [8:0] fast_limit;

  cmc_sync3 #(
    .WIDTH(6)
  ) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i({CHARGE_PERMIT_PIN_I, INPUT_VALID_I, OTG_OVERLOAD_I, DISCHARGE_OVERCURRENT_I,
      ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I, ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I}),
    .q_o({pin_s, valid_s, ovl_s, doc_s, adaptive_input_limit_loop_s, floor_s})
  );

  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_en = bus_req && WB_WE_I;
  assign wr_mode = WB_DAT_I[`CMC_MODE_MSB:`CMC_MODE_LSB];

  // register writes and bus answer
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_field_ff <= `CMC_RST_MODE;
      fchg_field_ff <= `CMC_RST_FCHG;
      otg_ilim_ff <= `CMC_RST_OTG_ILIM;
      doc_ff <= `CMC_RST_DOC;
      ilim_field_ff <= `CMC_RST_ILIM;
      vbyp_ff <= `CMC_RST_VBYP;
      manual_sel_ff <= 1'b0;
      vinreg_ff <= `CMC_RST_VINREG;
      permit_bit_ff <= `CMC_RST_PERMIT;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req) begin
        WB_DAT_O <= WB_WE_I ? 32'h00000000 : rd_data;
      end
      if (wr_en && WB_SEL_I[0]) begin
        case (WB_ADR_I)
          `CMC_ADR_CFG_MODE: begin
            mode_field_ff <= wr_mode;
            fchg_field_ff <= WB_DAT_I[`CMC_FCHG_MSB:`CMC_FCHG_LSB];
          end
          `CMC_ADR_CFG_LIMITS: begin
            otg_ilim_ff <= WB_DAT_I[`CMC_OTG_ILIM_MSB:`CMC_OTG_ILIM_LSB];
            doc_ff <= WB_DAT_I[`CMC_DOC_MSB:`CMC_DOC_LSB];
          end
          `CMC_ADR_CFG_INPUT: begin
            ilim_field_ff <= WB_DAT_I[`CMC_ILIM_MSB:`CMC_ILIM_LSB];
          end
          `CMC_ADR_CFG_SELECT: begin
            manual_sel_ff <= WB_DAT_I[`CMC_MANUAL_BIT];
            // R16 regulation level
            vinreg_ff <= WB_DAT_I[`CMC_VINREG_MSB:`CMC_VINREG_LSB];
          end
          `CMC_ADR_CFG_PERMIT: begin
            permit_bit_ff <= WB_DAT_I[`CMC_PERMIT_BIT];
          end
          default: begin
          end
        endcase
      end
      if (wr_en && WB_SEL_I[1] && WB_ADR_I == `CMC_ADR_CFG_INPUT) begin
        vbyp_ff <= WB_DAT_I[`CMC_VBYP_MSB:`CMC_VBYP_LSB];
      end
    end
  end

  // read mux, unmapped reads as zero
  always @* begin
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      `CMC_ADR_CFG_MODE: begin
        rd_data[`CMC_MODE_MSB:`CMC_MODE_LSB] = mode_field_ff;
        rd_data[`CMC_FCHG_MSB:`CMC_FCHG_LSB] = fchg_field_ff;
      end
      `CMC_ADR_CFG_LIMITS: begin
        rd_data[`CMC_OTG_ILIM_MSB:`CMC_OTG_ILIM_LSB] = otg_ilim_ff;
        rd_data[`CMC_DOC_MSB:`CMC_DOC_LSB] = doc_ff;
      end
      `CMC_ADR_CFG_INPUT: begin
        rd_data[`CMC_ILIM_MSB:`CMC_ILIM_LSB] = ilim_field_ff;
        rd_data[`CMC_VBYP_MSB:`CMC_VBYP_LSB] = vbyp_ff;
      end
      `CMC_ADR_CFG_SELECT: begin
        rd_data[`CMC_MANUAL_BIT] = manual_sel_ff;
        rd_data[`CMC_VINREG_MSB:`CMC_VINREG_LSB] = vinreg_ff;
      end
      `CMC_ADR_CFG_PERMIT: begin
        rd_data[`CMC_PERMIT_BIT] = permit_bit_ff;
      end
      `CMC_ADR_STATUS: begin
        rd_data[`CMC_ST_VALID_BIT] = valid_s;
        rd_data[`CMC_ST_FAULT_BIT] = fault_ff;
        rd_data[`CMC_ST_CHG_BIT] = CHARGE_EN_O;
        rd_data[`CMC_ST_INSW_BIT] = INPUT_SWITCH_ON_O;
        rd_data[`CMC_ST_DETAIL_MSB:`CMC_ST_DETAIL_LSB] = fault_ff ? `CMC_DETAIL_TIMER_FAULT :
          {1'b0, PROFILE_STATE_I};
        rd_data[`CMC_ST_MODE_MSB:`CMC_ST_MODE_LSB] = act_mode_ff;
      end
      default: begin
      end
    endcase
  end

  // operating mode decode from mode field writes
  always @* begin
    nxt_act_mode = act_mode_ff;
    if (wr_en && WB_SEL_I[0] && WB_ADR_I == `CMC_ADR_CFG_MODE) begin
      case (wr_mode)
        // R10 battery only
        4'h0, 4'h1: begin
          nxt_act_mode = MD_BATT_ONLY;
        end
        4'h4: begin
          nxt_act_mode = MD_CHG_OFF;
        end
        // R9 charger on
        4'h5: begin
          nxt_act_mode = MD_CHG_ON;
        end
        // R2 reverse boost
        4'h8, 4'h9: begin
          nxt_act_mode = MD_REV_BOOST;
        end
        // R7 otg needs pin
        4'hA, 4'hB: begin
          if (pin_s) begin
            nxt_act_mode = MD_OTG;
          end
        end
        // R11 codes ignored
        default: begin
          nxt_act_mode = act_mode_ff;
        end
      endcase
    end else if (act_mode_ff == MD_OTG && !pin_s) begin
      nxt_act_mode = MD_BATT_ONLY;
    end
  end

  // millisecond enable divider
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_cnt_ff <= 16'h0000;
      ms_tick_ff <= 1'b0;
    end else if (div_cnt_ff == MS_CYCLES[15:0] - 16'h0001) begin
      div_cnt_ff <= 16'h0000;
      ms_tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
      ms_tick_ff <= 1'b0;
    end
  end

  // otg overload retry sequence
  always @* begin
    nxt_otg_st = otg_st_ff;
    nxt_otg_cnt = otg_cnt_ff;
    if (act_mode_ff != MD_OTG) begin
      nxt_otg_st = OTG_ST_CLOSED;
      nxt_otg_cnt = 9'h000;
    end else begin
      case (otg_st_ff)
        // R5 open on overload
        OTG_ST_CLOSED: begin
          if (ovl_s) begin
            nxt_otg_st = OTG_ST_OPEN;
            nxt_otg_cnt = 9'h000;
          end
        end
        // R5 retry after 300ms
        OTG_ST_OPEN: begin
          if (ms_tick_ff) begin
            if (otg_cnt_ff == OTG_OFF_TICKS - 9'h001) begin
              nxt_otg_st = OTG_ST_RETRY;
              nxt_otg_cnt = 9'h000;
            end else begin
              nxt_otg_cnt = otg_cnt_ff + 9'h001;
            end
          end
        end
        // R6 hold closed 60ms
        OTG_ST_RETRY: begin
          if (ms_tick_ff) begin
            if (otg_cnt_ff == OTG_ON_TICKS - 9'h001) begin
              nxt_otg_st = ovl_s ? OTG_ST_OPEN : OTG_ST_CLOSED;
              nxt_otg_cnt = 9'h000;
            end else begin
              nxt_otg_cnt = otg_cnt_ff + 9'h001;
            end
          end
        end
        default: begin
          nxt_otg_st = OTG_ST_CLOSED;
          nxt_otg_cnt = 9'h000;
        end
      endcase
    end
  end

  assign in_pq = PROFILE_STATE_I == PF_PRECHARGE || PROFILE_STATE_I == PF_TRICKLE;
  assign in_fast = PROFILE_STATE_I == PF_FAST_CC || PROFILE_STATE_I == PF_FAST_CV ||
    PROFILE_STATE_I == PF_TOPOFF;
  assign group = {in_fast, in_pq};
  // R21 fault exit events
  assign fault_exit = (valid_s && !valid_old_ff) || (pin_s && !pin_old_ff) ||
    (permit_bit_ff && !permit_bit_old_ff);
  // R22 restart on group entry
  assign pq_clear = (in_pq && !group_old_ff[0]) || fault_exit;
  assign fast_clear = (in_fast && !group_old_ff[1]) || fault_exit;
  assign fast_limit = FCHG_STEP * {6'h00, fchg_field_ff};
  // R13 profile gates charging
  assign charge_run = act_mode_ff == MD_CHG_ON && permit_bit_ff && pin_s && valid_s &&
    PROFILE_CHARGE_REQ_I && !fault_ff && !(adaptive_input_limit_loop_s && floor_s);
  // set only from clear state, so an exit is not swallowed by a stale expiry
  assign fault_set = !fault_ff && ((pq_exp && in_pq) || (fast_exp && in_fast));

  // R18 precharge timer
  cmc_safety_timer #(
    .MIN_MS(MIN_MS)
  ) u_pq_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ms_tick_i(ms_tick_ff),
    .clear_i(pq_clear),
    .run_i(in_pq && charge_run),
    .limit_i(PQ_LIMIT),
    .expired_o(pq_exp)
  );

  // R19 fast charge timer
  cmc_safety_timer #(
    .MIN_MS(MIN_MS)
  ) u_fast_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ms_tick_i(ms_tick_ff),
    .clear_i(fast_clear),
    .run_i(in_fast && charge_run),
    .limit_i(fast_limit),
    .expired_o(fast_exp)
  );

  // state registers and outputs
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      act_mode_ff <= MD_CHG_ON;
      otg_st_ff <= OTG_ST_CLOSED;
      otg_cnt_ff <= 9'h000;
      doc_trip_ff <= 1'b0;
      fault_ff <= 1'b0;
      pin_old_ff <= 1'b0;
      valid_old_ff <= 1'b0;
      permit_bit_old_ff <= `CMC_RST_PERMIT;
      group_old_ff <= 2'h0;
      BUCK_EN_O <= 1'b0;
      BOOST_EN_O <= 1'b0;
      OTG_EN_O <= 1'b0;
      CHARGE_EN_O <= 1'b0;
      INPUT_SWITCH_ON_O <= 1'b0;
      BATTERY_SWITCH_ON_O <= 1'b1;
      BYP_FIXED_5V1_O <= 1'b0;
      BYP_TARGET_O <= `CMC_RST_VBYP;
      OTG_ILIM_O <= `CMC_RST_OTG_ILIM;
      DISCHARGE_OC_THRESH_O <= `CMC_RST_DOC;
      INPUT_LIMIT_O <= `CMC_RST_ILIM;
      VIN_REG_O <= `CMC_RST_VINREG;
      STAT_O <= 1'b1;
      STAT_OE_O <= 1'b1;
    end else begin
      act_mode_ff <= nxt_act_mode;
      otg_st_ff <= nxt_otg_st;
      otg_cnt_ff <= nxt_otg_cnt;
      pin_old_ff <= pin_s;
      valid_old_ff <= valid_s;
      permit_bit_old_ff <= permit_bit_ff;
      group_old_ff <= group;
      // R4 overcurrent trip
      if (act_mode_ff == MD_REV_BOOST && doc_s) begin
        doc_trip_ff <= 1'b1;
      end else if (act_mode_ff != MD_REV_BOOST) begin
        doc_trip_ff <= 1'b0;
      end
      // R20 timer fault latch
      if (fault_set) begin
        fault_ff <= 1'b1;
      end else if (fault_exit) begin
        fault_ff <= 1'b0;
      end
      BUCK_EN_O <= act_mode_ff == MD_CHG_ON || act_mode_ff == MD_CHG_OFF;
      BOOST_EN_O <= act_mode_ff == MD_REV_BOOST || act_mode_ff == MD_OTG;
      OTG_EN_O <= act_mode_ff == MD_OTG;
      // R17 R20 floor or expiry shutdown
      CHARGE_EN_O <= charge_run && !fault_set;
      // R1 input switch in otg
      INPUT_SWITCH_ON_O <= (act_mode_ff == MD_OTG && nxt_otg_st != OTG_ST_OPEN) ||
        act_mode_ff == MD_CHG_ON || act_mode_ff == MD_CHG_OFF;
      // R4 open battery switch
      BATTERY_SWITCH_ON_O <= !(doc_trip_ff || (act_mode_ff == MD_REV_BOOST && doc_s));
      BYP_FIXED_5V1_O <= act_mode_ff == MD_OTG;
      // R3 programmed bypass target
      BYP_TARGET_O <= vbyp_ff;
      OTG_ILIM_O <= otg_ilim_ff;
      DISCHARGE_OC_THRESH_O <= doc_ff;
      // R14 R15 detected or manual limit
      INPUT_LIMIT_O <= manual_sel_ff ? ilim_field_ff : USB_DET_LIMIT_I;
      VIN_REG_O <= vinreg_ff;
      // R20 status pin released
      STAT_OE_O <= !(fault_ff || fault_set);
      STAT_O <= !charge_run;
    end
  end
endmodule // cmc_top

// ### tb/cmc_checker.sv
// port assertions for the charger mode control
`timescale 1ns/100ps
module cmc_checker #(
  parameter MS_CYCLES = 20000,
  parameter MIN_MS = 60000
) (
  input wire CLOCK_I,
  input wire RST_N_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire CHARGE_PERMIT_PIN_I,
  input wire DISCHARGE_OVERCURRENT_I,
  input wire ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I,
  input wire ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I,
  input wire BUCK_EN_O,
  input wire BOOST_EN_O,
  input wire OTG_EN_O,
  input wire CHARGE_EN_O,
  input wire INPUT_SWITCH_ON_O,
  input wire BATTERY_SWITCH_ON_O,
  input wire BYP_FIXED_5V1_O,
  input wire STAT_OE_O
);
  localparam integer OFF_CYC = 300 * MS_CYCLES;
  reg [31:0] off_cnt_ff;
  wire [31:0] nxt_off_cnt = (OTG_EN_O && !INPUT_SWITCH_ON_O) ? off_cnt_ff + 32'h1 : 32'h0;
  // counts otg cycles with switch open
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      off_cnt_ff <= 32'h0;
    end else begin
      off_cnt_ff <= nxt_off_cnt;
    end
  end
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  chk_ack_pulse: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack not a single pulse after request");
  chk_otg_drive: assert property (OTG_EN_O |-> BOOST_EN_O && !BUCK_EN_O && BYP_FIXED_5V1_O && !CHARGE_EN_O)
    else $error("otg outputs wrong");
  chk_rev_boost: assert property ((BOOST_EN_O && !OTG_EN_O)
    |-> !INPUT_SWITCH_ON_O && !BUCK_EN_O && !BYP_FIXED_5V1_O)
    else $error("reverse boost outputs wrong");
  chk_rev_oc: assert property ((BOOST_EN_O && !OTG_EN_O && DISCHARGE_OVERCURRENT_I) [*8]
    |-> !BATTERY_SWITCH_ON_O)
    else $error("battery switch kept on under overcurrent");
  chk_otg_permit: assert property (!CHARGE_PERMIT_PIN_I [*8] |-> !OTG_EN_O)
    else $error("otg on without permit pin");
  chk_otg_offtime: assert property (($rose(INPUT_SWITCH_ON_O) && OTG_EN_O && off_cnt_ff > 8)
    |-> off_cnt_ff >= OFF_CYC - 4 && off_cnt_ff <= OFF_CYC + 4)
    else $error("otg retry off time wrong");
  chk_batt_only: assert property ((!BUCK_EN_O && !BOOST_EN_O)
    |-> !INPUT_SWITCH_ON_O && !CHARGE_EN_O && !OTG_EN_O)
    else $error("battery only outputs wrong");
  chk_charge_buck: assert property (CHARGE_EN_O |-> BUCK_EN_O && INPUT_SWITCH_ON_O && !BOOST_EN_O)
    else $error("charging without buck");
  chk_adaptive_input_limit_loop_floor: assert property ((ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I && ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I) [*6] |-> !CHARGE_EN_O)
    else $error("charging at adaptive floor");
  chk_fault_hold: assert property ($fell(STAT_OE_O) |-> !CHARGE_EN_O [*3])
    else $error("charging during timer fault");
  cover property (OTG_EN_O && !INPUT_SWITCH_ON_O);
  cover property ($fell(STAT_OE_O));
  cover property (BOOST_EN_O && !OTG_EN_O && !BATTERY_SWITCH_ON_O);
endmodule // cmc_checker

bind cmc_top cmc_checker #(.MS_CYCLES(MS_CYCLES), .MIN_MS(MIN_MS)) cmc_checker_i (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .CHARGE_PERMIT_PIN_I(CHARGE_PERMIT_PIN_I), .DISCHARGE_OVERCURRENT_I(DISCHARGE_OVERCURRENT_I),
  .ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I(ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I), .ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I(ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I), .BUCK_EN_O(BUCK_EN_O),
  .BOOST_EN_O(BOOST_EN_O), .OTG_EN_O(OTG_EN_O), .CHARGE_EN_O(CHARGE_EN_O),
  .INPUT_SWITCH_ON_O(INPUT_SWITCH_ON_O), .BATTERY_SWITCH_ON_O(BATTERY_SWITCH_ON_O),
  .BYP_FIXED_5V1_O(BYP_FIXED_5V1_O), .STAT_OE_O(STAT_OE_O));

// ### tb/cmc_host_model.sv
// host bus master model for the charger registers
`timescale 1ns/100ps
module cmc_host_model (
  input wire clk_i,
  input wire ack_i,
  input wire [31:0] rdat_i,
  output reg cyc_o,
  output reg stb_o,
  output reg we_o,
  output reg [7:0] adr_o,
  output reg [3:0] sel_o,
  output reg [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0;
  end
  task xfer(input reg w, input reg [7:0] a, input reg [31:0] d, output reg [31:0] q);
    begin
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1) begin
        @(posedge clk_i);
      end
      q = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
    end
  endtask
endmodule // cmc_host_model

// ### tb/testbench.sv
// self-checking bench for the charger mode control
`timescale 1ns/100ps
`include "cmc_map.vh"
module testbench;
  localparam MSC = 4;
  localparam MIN = 10;
  localparam integer T_PQ = 30 * MIN * MSC;
  localparam integer T_FC = 60 * MIN * MSC;
  localparam integer T_OFF = 300 * MSC;
  localparam integer T_ON = 60 * MSC;
  // code then expected buck, boost, otg, input switch
  localparam [127:0] MT = 128'h00_20_59_C9_10_84_74_94_A7_F7_B7_37_67_D7_E7_59;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg pin = 1'b1;
  reg valid = 1'b1;
  reg ovl = 1'b0;
  reg doc = 1'b0;
  reg aa = 1'b0;
  reg af = 1'b0;
  reg preq = 1'b1;
  reg [5:0] usb = 6'h15;
  reg [2:0] pst = 3'h0;
  reg [31:0] q;
  integer bad_count = 0;
  integer n_compared = 0;
  integer c;
  wire cyc, stb, we, ack, buck, boost, otg, chg, insw, bsw, fix, stat, stoe;
  wire [7:0] adr;
  wire [3:0] sel, bypass_node, oil, dth, vreg;
  wire [31:0] wd, rd;
  wire [5:0] ilim;
  initial begin
    forever #25 clk = ~clk;
  end
  cmc_host_model cmc_host_model_i (.clk_i(clk), .ack_i(ack), .rdat_i(rd), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  cmc_top #(.MS_CYCLES(MSC), .MIN_MS(MIN)) cmc_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd),
    .WB_ACK_O(ack), .CHARGE_PERMIT_PIN_I(pin), .INPUT_VALID_I(valid), .OTG_OVERLOAD_I(ovl),
    .DISCHARGE_OVERCURRENT_I(doc), .ADAPTIVE_INPUT_LIMIT_LOOP_ACTIVE_I(aa), .ADAPTIVE_INPUT_LIMIT_LOOP_AT_FLOOR_I(af), .USB_DET_LIMIT_I(usb),
    .PROFILE_STATE_I(pst), .PROFILE_CHARGE_REQ_I(preq), .BUCK_EN_O(buck), .BOOST_EN_O(boost),
    .OTG_EN_O(otg), .CHARGE_EN_O(chg), .INPUT_SWITCH_ON_O(insw), .BATTERY_SWITCH_ON_O(bsw),
    .BYP_FIXED_5V1_O(fix), .BYP_TARGET_O(bypass_node), .OTG_ILIM_O(oil), .DISCHARGE_OC_THRESH_O(dth),
    .INPUT_LIMIT_O(ilim), .VIN_REG_O(vreg), .STAT_O(stat), .STAT_OE_O(stoe));
  task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    cmc_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task rdr(input [7:0] a);
    cmc_host_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  // edges until input switch (s=0) or status enable (s=1) reads v
  task wait_sig(input s, input v);
    begin
      c = 0;
      while (((s ? stoe : insw) !== v) && c < 5000) begin
        @(posedge clk);
        c = c + 1;
      end
    end
  endtask
  task t_limit;
    begin
      check(ilim, 6'h15, "ilim_auto");
      check(vreg, 4'h0, "vreg_rst");
      rdr(`CMC_ADR_CFG_MODE);
      check(q[6:0], 7'h35, "mode_rst");
      wr(`CMC_ADR_CFG_INPUT, 32'h0A2A);
      tick(2);
      check(ilim, 6'h15, "ilim_keep");
      wr(`CMC_ADR_CFG_SELECT, 32'h71);
      tick(2);
      check({vreg, ilim}, 10'h1EA, "ilim_man");
      rdr(8'h20);
      check(q, 32'h0, "unmapped");
    end
  endtask
  task t_modes;
    reg [7:0] e;
    integer i;
    begin
      valid <= 1'b0;
      tick(6);
      for (i = 0; i < 16; i = i + 1) begin
        e = MT[127-8*i -: 8];
        wr(`CMC_ADR_CFG_MODE, {24'h0, 4'h3, e[7:4]});
        tick(3);
        check({buck, boost, otg, insw}, e[3:0], "mode_out");
        check(fix, e[1], "fix_5v1");
      end
    end
  endtask
  task t_otg;
    begin
      wr(`CMC_ADR_CFG_MODE, 32'h30);
      pin <= 1'b0;
      tick(8);
      wr(`CMC_ADR_CFG_MODE, 32'h3A);
      tick(3);
      check(otg, 1'b0, "otg_nopin");
      pin <= 1'b1;
      tick(8);
      wr(`CMC_ADR_CFG_MODE, 32'h3A);
      tick(3);
      check(otg, 1'b1, "otg_pin");
      ovl <= 1'b1;
      wait_sig(0, 1'b0);
      check(c < 10, 1'b1, "trip");
      wait_sig(0, 1'b1);
      check(c >= T_OFF - 4 && c <= T_OFF + 4, 1'b1, "off_time");
      wait_sig(0, 1'b0);
      check(c >= T_ON - 4 && c <= T_ON + 4, 1'b1, "on_time");
      ovl <= 1'b0;
      wait_sig(0, 1'b1);
      tick(T_OFF + T_ON);
      check(insw, 1'b1, "otg_ok");
    end
  endtask
  task t_rev;
    begin
      wr(`CMC_ADR_CFG_LIMITS, 32'h5C);
      wr(`CMC_ADR_CFG_MODE, 32'h38);
      tick(3);
      check({bypass_node, oil, dth, bsw}, 13'h158B, "rev_field");
      doc <= 1'b1;
      tick(10);
      check(bsw, 1'b0, "bsw_oc");
      doc <= 1'b0;
      wr(`CMC_ADR_CFG_MODE, 32'h30);
      tick(3);
      check(bsw, 1'b1, "bsw_back");
    end
  endtask
  task t_charge;
    begin
      valid <= 1'b1;
      wr(`CMC_ADR_CFG_MODE, 32'h35);
      tick(8);
      check(chg, 1'b1, "chg_on");
      check({stoe, stat}, 2'h2, "stat_drv");
      preq <= 1'b0;
      tick(3);
      check(chg, 1'b0, "prof_off");
      preq <= 1'b1;
      aa <= 1'b1;
      af <= 1'b1;
      tick(8);
      check(chg, 1'b0, "adaptive_input_limit_loop_off");
      aa <= 1'b0;
      af <= 1'b0;
      tick(8);
      check(chg, 1'b1, "adaptive_input_limit_loop_back");
    end
  endtask
  task t_timer;
    begin
      pst <= 3'h1;
      tick(T_PQ / 2);
      pst <= 3'h3;
      tick(4);
      pst <= 3'h2;
      wait_sig(1, 1'b0);
      check(c >= T_PQ - 6 && c <= T_PQ + 6, 1'b1, "pq_time");
      tick(2);
      check(chg, 1'b0, "flt_chg");
      rdr(`CMC_ADR_STATUS);
      check({q[7:4], q[1]}, 5'h0D, "flt_stat");
      wr(`CMC_ADR_CFG_PERMIT, 32'h0);
      wr(`CMC_ADR_CFG_PERMIT, 32'h1);
      tick(3);
      check({stoe, chg}, 2'h3, "exit_bit");
      wait_sig(1, 1'b0);
      check(stoe, 1'b0, "flt_again");
      pin <= 1'b0;
      tick(8);
      pin <= 1'b1;
      tick(8);
      check(stoe, 1'b1, "exit_pin");
      wr(`CMC_ADR_CFG_MODE, 32'h15);
      pst <= 3'h4;
      wait_sig(1, 1'b0);
      check(c >= T_FC - 8 && c <= T_FC + 8, 1'b1, "fc_time");
      valid <= 1'b0;
      tick(8);
      valid <= 1'b1;
      tick(8);
      check(stoe, 1'b1, "exit_vin");
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    t_limit;
    t_modes;
    t_otg;
    t_rev;
    t_charge;
    t_timer;
    wrap_up;
  end
  initial begin
    tick(40000);
    bad_count = bad_count + 1;
    wrap_up;
  end
endmodule // testbench
